// >>> verilog/pch_power_cond_subcmd.sv
module pch_power_cond_subcmd (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // apb request
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  // apb answer
  output logic                             pready,
  output logic [31:0]                      prdata,
  output logic                             pslverr,
  // power condition state
  output logic [2:0]                       pwr_cond_idx,
  output logic                             pwr_cond_forced,
  output logic [pch_pkg::NCOND-1:0]        timer_running
);
  import pch_pkg::*;

  // apb answer flops
  logic                 pready_r;
  logic [31:0]          prdata_r;
  logic                 pslverr_r;

  // command block registers as the host wrote them
  logic [7:0]           feat_r;
  logic [7:0]           cid_r;
  logic [7:0]           subc_r;
  logic [7:0]           tlo_r;
  logic [7:0]           thi_r;
  logic [7:0]           dsel_r;
  logic [7:0]           cmd_r;

  // reported error and status flags
  logic [7:0]           err_r;
  logic [7:0]           stat_r;

  // feature enable and per-condition capabilities
  logic                 epc_en_r;
  logic [NCOND-1:0]     supp_r;
  logic [NCOND-1:0]     chg_r;
  logic [NCOND-1:0]     savok_r;

  // timer read-back select
  logic [2:0]           tsel_r;

  // power condition state
  logic [2:0]           pwr_cond_r;
  logic                 forced_r;
  logic                 halted_r;
  logic [NCOND-1:0]     run_r;

  // command sequencer
  pch_state_t           state_r;
  pch_state_t           state_nxt;

  // per-condition settings gathered from the loop
  wire  logic [TMR_W-1:0] cur_tmr_w [NCOND];
  wire  logic [TMR_W-1:0] sav_tmr_w [NCOND];
  wire  logic [NCOND-1:0] cur_en_w;
  wire  logic [NCOND-1:0] sav_en_w;

  // bus decode
  logic                 acc_first;
  logic                 wr_fire;
  logic                 cmd_fire;
  logic                 mapped;
  logic [31:0]          rd_data;

  // command decode and timer datapath
  pch_cmd_t             c;
  logic [NCOND-1:0]     sel;
  logic [NCOND-1:0]     sel_go;
  logic                 abort;
  logic                 exec_ok;
  logic [2:0]           go_idx;
  logic [25:0]          tmr_scaled;
  logic [TMR_W-1:0]     tmr_clamped;

  // apb phase decode
  assign acc_first = psel & penable & ~pready_r;
  assign wr_fire   = psel & penable & pready_r & pwrite;
  assign cmd_fire  = wr_fire & (paddr == ADDR_COMMAND);

  // read mux; command block inputs read back as zero
  always_comb begin
    rd_data = '0;
    mapped  = 1'b1;
    case (paddr)
      ADDR_FEATURE, ADDR_COND_ID, ADDR_SUBCTRL, ADDR_TMR_LO,
      ADDR_TMR_HI, ADDR_DEV_SEL, ADDR_COMMAND: rd_data = '0;
      ADDR_ERROR:     rd_data[7:0] = err_r;
      ADDR_STATUS:    rd_data[7:0] = stat_r;
      ADDR_EPC_CTRL:  rd_data[0] = epc_en_r;
      ADDR_COND_CAPS: begin
        rd_data[CAP_SUPP_LSB +: NCOND] = supp_r;
        rd_data[CAP_CHG_LSB +: NCOND]  = chg_r;
        rd_data[CAP_SAV_LSB +: NCOND]  = savok_r;
      end
      ADDR_PWR_STATE: rd_data = {21'h000000, run_r, halted_r, forced_r, 1'b0, pwr_cond_r};
      ADDR_TMR_SEL:   rd_data[2:0] = tsel_r;
      // timer views of the selected condition; an out-of-range select reads zero
      ADDR_TMR_CUR: begin
        if (tsel_r < 3'(NCOND)) begin
          rd_data[TMR_W-1:0]  = cur_tmr_w[tsel_r];
          rd_data[EN_FLAG_BIT] = cur_en_w[tsel_r];
        end
      end
      ADDR_TMR_SAVED: begin
        if (tsel_r < 3'(NCOND)) begin
          rd_data[TMR_W-1:0]  = sav_tmr_w[tsel_r];
          rd_data[EN_FLAG_BIT] = sav_en_w[tsel_r];
        end
      end
      default:        mapped = 1'b0;
    endcase
  end

  // apb answer: one wait state, data captured in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= '0;
      pslverr_r <= 1'b0;
    end else if (acc_first) begin
      pready_r  <= 1'b1;
      prdata_r  <= pwrite ? 32'h0000_0000 : rd_data;
      pslverr_r <= ~mapped;
    end else begin
      // prdata_r keeps its value; it is only looked at with pready
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // command block and configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feat_r   <= '0;
      cid_r    <= '0;
      subc_r   <= '0;
      tlo_r    <= '0;
      thi_r    <= '0;
      dsel_r   <= '0;
      cmd_r    <= '0;
      epc_en_r <= EPC_EN_RST;
      supp_r   <= CAPS_RST;
      chg_r    <= CAPS_RST;
      savok_r  <= CAPS_RST;
      tsel_r   <= '0;
    end else if (wr_fire) begin
      case (paddr)
        ADDR_FEATURE:   feat_r <= pwdata[7:0];
        ADDR_COND_ID:   cid_r <= pwdata[7:0];
        ADDR_SUBCTRL:   subc_r <= pwdata[7:0];
        ADDR_TMR_LO:    tlo_r <= pwdata[7:0];
        ADDR_TMR_HI:    thi_r <= pwdata[7:0];
        ADDR_DEV_SEL:   dsel_r <= pwdata[7:0];
        ADDR_COMMAND:   cmd_r <= pwdata[7:0];
        ADDR_EPC_CTRL:  epc_en_r <= pwdata[0];
        ADDR_COND_CAPS: begin
          supp_r  <= pwdata[CAP_SUPP_LSB +: NCOND];
          chg_r   <= pwdata[CAP_CHG_LSB +: NCOND];
          savok_r <= pwdata[CAP_SAV_LSB +: NCOND];
        end
        ADDR_TMR_SEL:   tsel_r <= pwdata[2:0];
        default:        tsel_r <= tsel_r;
      endcase
    end
  end

  // decoded command block fields
  assign c.cond_id = cid_r;
  assign c.units   = subc_r[7];
  assign c.dflt    = subc_r[6];
  assign c.enable  = subc_r[5];
  assign c.save    = subc_r[4];
  assign c.code    = subc_r[3:0];
  assign c.timer   = {thi_r, tlo_r};

  // condition selection; FFh selects every supported condition in sel, none in sel_go for go-to
  for (genvar g = 0; g < NCOND; g++) begin : g_sel
    assign sel[g]    = (c.cond_id == COND_ALL) ? supp_r[g] : (c.cond_id == COND_ID[g]);
    assign sel_go[g] = (c.cond_id == COND_ID[g]) & supp_r[g];
  end

  // timer scaling to 100 ms units and clamping; unsigned so never below zero
  assign tmr_scaled  = c.units ? ({10'h000, c.timer} * 26'(UNITS_PER_MINUTE)) : {10'h000, c.timer};
  assign tmr_clamped = (tmr_scaled > {4'h0, TMR_MAX}) ? TMR_MAX : tmr_scaled[TMR_W-1:0];

  // abort decision
  always_comb begin
    abort = 1'b1;
    if ((cmd_r == CMD_SET_FEATURES) && (feat_r == FEAT_EPC)) begin
      case (c.code)
        // restore and set-timer share the capability checks
        SUB_RESTORE, SUB_TIMER: begin
          abort = ~epc_en_r | ~(|sel) | (|(sel & ~(supp_r & chg_r)))
                  | (c.save & (|(sel & ~savok_r)));
        end
        // go-to needs one exact, supported condition
        SUB_GOTO: begin
          abort = ~epc_en_r | (c.cond_id == COND_ALL) | ~(|sel_go);
        end
        default: abort = 1'b1;
      endcase
    end
  end

  assign exec_ok = (state_r == PCH_EXEC) & ~abort;

  // index of the go-to target
  always_comb begin
    go_idx = COND_NONE;
    for (int i = 0; i < NCOND; i++) begin
      if (sel_go[i]) begin
        go_idx = 3'(i);
      end
    end
  end

  // per-condition settings
  for (genvar g = 0; g < NCOND; g++) begin : g_cond
    logic [TMR_W-1:0] cur_tmr_q;
    logic [TMR_W-1:0] sav_tmr_q;
    logic             cur_en_q;
    logic             sav_en_q;
    logic [TMR_W-1:0] rst_tmr;
    logic             rst_en;
    logic             new_en;
    logic             upd;

    // restore source: default or saved copy
    assign rst_tmr = c.dflt ? DEF_TMR[g] : sav_tmr_q;
    assign rst_en  = c.dflt ? DEF_EN[g] : sav_en_q;
    // set-timer enable needs a non-zero raw timer field
    assign new_en  = c.enable & (c.timer != 16'h0000);
    // only a selected condition of a command that did not abort changes
    assign upd     = exec_ok & sel[g];

    // restore and set-timer updates; saved copies only where savable
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cur_tmr_q <= DEF_TMR[g];
        sav_tmr_q <= DEF_TMR[g];
        cur_en_q  <= DEF_EN[g];
        sav_en_q  <= DEF_EN[g];
      end else if (upd && (c.code == SUB_RESTORE)) begin
        cur_tmr_q <= rst_tmr;
        cur_en_q  <= rst_en;
        if (c.save && savok_r[g]) begin
          sav_tmr_q <= rst_tmr;
        end
      end else if (upd && (c.code == SUB_TIMER)) begin
        cur_tmr_q <= tmr_clamped;
        cur_en_q  <= new_en;
        if (c.save && savok_r[g]) begin
          sav_tmr_q <= tmr_clamped;
          sav_en_q  <= new_en;
        end
      end
    end

    assign cur_tmr_w[g] = cur_tmr_q;
    assign sav_tmr_w[g] = sav_tmr_q;
    assign cur_en_w[g]  = cur_en_q;
    assign sav_en_w[g]  = sav_en_q;
  end

  // command sequencer: busy for one cycle while the command executes
  always_comb begin
    case (state_r)
      PCH_IDLE: state_nxt = cmd_fire ? PCH_EXEC : PCH_IDLE;
      PCH_EXEC: state_nxt = PCH_IDLE;
      default:  state_nxt = PCH_IDLE;
    endcase
  end

  // sequencer state flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= PCH_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // error and status reporting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_r  <= '0;
      stat_r <= STATUS_RST;
    end else if (cmd_fire) begin
      // busy while the command executes
      err_r          <= '0;
      stat_r         <= '0;
      stat_r[ST_BSY] <= 1'b1;
      stat_r[ST_RDY] <= 1'b1;
    end else if (state_r == PCH_EXEC) begin
      // completion: ready, with abort and error when refused
      err_r          <= '0;
      err_r[ERR_ABT] <= abort;
      stat_r         <= '0;
      stat_r[ST_RDY] <= 1'b1;
      stat_r[ST_ERR] <= abort;
    end
  end

  // power condition: forced by go-to, released by the next command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_cond_r <= COND_NONE;
      forced_r   <= 1'b0;
      halted_r   <= 1'b0;
    end else if (cmd_fire) begin
      // any command write releases a forced condition
      forced_r   <= 1'b0;
      halted_r   <= 1'b0;
      pwr_cond_r <= COND_NONE;
    end else if (exec_ok && (c.code == SUB_GOTO)) begin
      // successful go-to: enter the target and halt the timers
      pwr_cond_r <= go_idx;
      forced_r   <= 1'b1;
      halted_r   <= 1'b1;
    end
  end

  // running timers: enabled and not halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r <= '0;
    end else begin
      run_r <= cur_en_w & {NCOND{~halted_r}};
    end
  end

  // outputs straight from their flops
  assign pready          = pready_r;
  assign prdata          = prdata_r;
  assign pslverr         = pslverr_r;
  assign pwr_cond_idx    = pwr_cond_r;
  assign pwr_cond_forced = forced_r;
  assign timer_running   = run_r;
endmodule : pch_power_cond_subcmd

// >>> verilog/pch_pkg.sv
package pch_pkg;
  localparam int          NCOND            = 5;
  localparam int          TMR_W            = 22;
  localparam logic [7:0]  CMD_SET_FEATURES = 8'hEF;
  localparam logic [7:0]  FEAT_EPC         = 8'h4A;
  localparam logic [3:0]  SUB_RESTORE      = 4'h0;
  localparam logic [3:0]  SUB_GOTO         = 4'h1;
  localparam logic [3:0]  SUB_TIMER        = 4'h2;
  localparam logic [7:0]  COND_ALL         = 8'hFF;
  localparam logic [7:0]  COND_ID [NCOND]  = '{8'h00, 8'h01, 8'h81, 8'h82, 8'h83};
  localparam logic [2:0]  COND_NONE        = 3'h7;
  // timer limits, in 100 ms units
  localparam logic [TMR_W-1:0] TMR_MAX     = 22'h3BFFC4;
  localparam logic [TMR_W-1:0] TMR_MIN     = 22'h000000;
  localparam int          TIMER_UNIT_MS    = 100;
  localparam int          MINUTE_MS        = 60000;
  localparam int          UNITS_PER_MINUTE = MINUTE_MS / TIMER_UNIT_MS;
  localparam logic [TMR_W-1:0] DEF_TMR [NCOND] = '{22'h000064, 22'h0000C8, 22'h000001, 22'h000032, 22'h000064};
  localparam logic [NCOND-1:0] DEF_EN      = 5'h1F;
  // error and status bit positions
  localparam int          ERR_ABT          = 2;
  localparam int          ST_BSY           = 7;
  localparam int          ST_RDY           = 6;
  localparam int          ST_ERR           = 0;
  // register byte addresses
  localparam logic [7:0]  ADDR_FEATURE     = 8'h00;
  localparam logic [7:0]  ADDR_COND_ID     = 8'h04;
  localparam logic [7:0]  ADDR_SUBCTRL     = 8'h08;
  localparam logic [7:0]  ADDR_TMR_LO      = 8'h0C;
  localparam logic [7:0]  ADDR_TMR_HI      = 8'h10;
  localparam logic [7:0]  ADDR_DEV_SEL     = 8'h14;
  localparam logic [7:0]  ADDR_COMMAND     = 8'h18;
  localparam logic [7:0]  ADDR_ERROR       = 8'h1C;
  localparam logic [7:0]  ADDR_STATUS      = 8'h20;
  localparam logic [7:0]  ADDR_EPC_CTRL    = 8'h24;
  localparam logic [7:0]  ADDR_COND_CAPS   = 8'h28;
  localparam logic [7:0]  ADDR_PWR_STATE   = 8'h2C;
  localparam logic [7:0]  ADDR_TMR_SEL     = 8'h30;
  localparam logic [7:0]  ADDR_TMR_CUR     = 8'h34;
  localparam logic [7:0]  ADDR_TMR_SAVED   = 8'h38;
  // capability field positions and reset values
  localparam int          CAP_SUPP_LSB     = 0;
  localparam int          CAP_CHG_LSB      = 8;
  localparam int          CAP_SAV_LSB      = 16;
  localparam int          EN_FLAG_BIT      = 31;
  localparam logic [NCOND-1:0] CAPS_RST    = 5'h1F;
  localparam logic        EPC_EN_RST       = 1'b1;
  localparam logic [7:0]  STATUS_RST       = 8'h40;

  typedef struct packed {
    logic [7:0]  cond_id;
    logic        units;
    logic        dflt;
    logic        enable;
    logic        save;
    logic [3:0]  code;
    logic [15:0] timer;
  } pch_cmd_t;

  typedef enum {PCH_IDLE, PCH_EXEC} pch_state_t;
endpackage : pch_pkg

// >>> verif/pch_properties.sv
module pch_properties (
  // clock and reset
  input wire logic                      pclk,
  input wire logic                      presetn,
  // apb request
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [7:0]                paddr,
  input wire logic [31:0]               pwdata,
  // apb answer
  input wire logic                      pready,
  input wire logic [31:0]               prdata,
  input wire logic                      pslverr,
  // power condition state
  input wire logic [2:0]                pwr_cond_idx,
  input wire logic                      pwr_cond_forced,
  input wire logic [pch_pkg::NCOND-1:0] timer_running
);
  timeunit 1ns;
  timeprecision 1ps;
  import pch_pkg::*;
  logic [7:0] feat_r, cond_r, sub_r;
  logic       epc_r, wr_ok, rd_ok, cmd_wr, go_sel;
  logic [2:0] exp_idx;
  // completed transfers and go-to command decode
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  assign rd_ok = psel && penable && pready && !pwrite;
  assign cmd_wr = wr_ok && paddr == ADDR_COMMAND;
  assign go_sel = cmd_wr && pwdata[7:0] == CMD_SET_FEATURES && feat_r == FEAT_EPC && sub_r[3:0] == SUB_GOTO && epc_r;
  // shadow of the command block as the host wrote it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feat_r <= 8'h00;
      cond_r <= 8'h00;
      sub_r <= 8'h00;
      epc_r <= EPC_EN_RST;
    end else if (wr_ok) begin
      if (paddr == ADDR_FEATURE) feat_r <= pwdata[7:0];
      if (paddr == ADDR_COND_ID) cond_r <= pwdata[7:0];
      if (paddr == ADDR_SUBCTRL) sub_r <= pwdata[7:0];
      if (paddr == ADDR_EPC_CTRL) epc_r <= pwdata[0];
    end
  end
  // condition index that a go-to should land in
  always_comb begin
    exp_idx = COND_NONE;
    for (int i = 0; i < NCOND; i++) if (cond_r == COND_ID[i]) exp_idx = 3'(i);
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_go_in; go_sel && exp_idx != COND_NONE |-> ##[1:4] (pwr_cond_forced && pwr_cond_idx == exp_idx); endproperty
  a_go_in: assert property (p_go_in) else $error("go-to entry wrong");
  property p_halt; pwr_cond_forced [*3] |-> timer_running == '0; endproperty
  a_halt: assert property (p_halt) else $error("timer runs while forced");
  property p_hold; pwr_cond_forced && !cmd_wr && !$past(cmd_wr) |=> pwr_cond_forced; endproperty
  a_hold: assert property (p_hold) else $error("forced state dropped");
  property p_free; $fell(pwr_cond_forced) |-> $past(cmd_wr) || $past(cmd_wr, 2) || $past(cmd_wr, 3); endproperty
  a_free: assert property (p_free) else $error("forced state left with no command");
  property p_go_ff; go_sel && cond_r == COND_ALL |-> ##3 !pwr_cond_forced [*3]; endproperty
  a_go_ff: assert property (p_go_ff) else $error("go-to to all conditions taken");
  property p_stat; rd_ok && paddr == ADDR_STATUS |-> prdata[7:5] == 3'b010 && !prdata[2]; endproperty
  a_stat: assert property (p_stat) else $error("status busy, fault or corrected set");
  property p_err; rd_ok && paddr == ADDR_ERROR |-> prdata[31:3] == '0 && prdata[1:0] == 2'b00; endproperty
  a_err: assert property (p_err) else $error("error flags beyond abort");
  property p_idx; pwr_cond_forced |-> pwr_cond_idx < 3'(NCOND); endproperty
  a_idx: assert property (p_idx) else $error("forced index out of range");
  c_go: cover property (go_sel && exp_idx != COND_NONE);
  c_ff: cover property (go_sel && cond_r == COND_ALL);
  c_free: cover property ($fell(pwr_cond_forced));
endmodule : pch_properties

// >>> verif/pch_host_model.sv
module pch_host_model (
  // clock
  input wire logic        pclk,
  // apb request
  output logic            psel,
  output logic            penable,
  output logic            pwrite,
  output logic [7:0]      paddr,
  output logic [31:0]     pwdata,
  // apb answer
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  import pch_pkg::*;
  // bus idle from time zero
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  // one transfer, held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // fill the command block, then trigger with the opcode
  task automatic cmd(input logic [7:0] id, input logic [7:0] ctl, input logic [15:0] tmr);
    logic [31:0] d;
    logic        e;
    xfer(1'b1, ADDR_FEATURE, {24'h0, FEAT_EPC}, d, e);
    xfer(1'b1, ADDR_COND_ID, {24'h0, id}, d, e);
    xfer(1'b1, ADDR_SUBCTRL, {24'h0, ctl}, d, e);
    xfer(1'b1, ADDR_TMR_LO, {24'h0, tmr[7:0]}, d, e);
    xfer(1'b1, ADDR_TMR_HI, {24'h0, tmr[15:8]}, d, e);
    xfer(1'b1, ADDR_COMMAND, {24'h0, CMD_SET_FEATURES}, d, e);
  endtask : cmd
endmodule : pch_host_model

// >>> verif/pch_power_cond_subcmd_test.sv
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
  $display("FAIL %s exp %0h got %0h", n, e, a); end end
module pch_power_cond_subcmd_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pch_pkg::*;
  logic             pclk, presetn = 1'b0, psel, penable, pwrite, pready, pslverr, rerr, forced = 1'b0, epc = 1'b1;
  logic [7:0]       paddr;
  logic [31:0]      pwdata, prdata, rdat, r, seed = 32'd55;
  logic [2:0]       pwr_cond_idx;
  logic             pwr_cond_forced;
  logic [NCOND-1:0] timer_running, savm = 5'h1F;
  int               error_cnt, checks_done, fidx, cur[NCOND], cen[NCOND], sav[NCOND], sen[NCOND];
  logic [31:0]      plan[$] = '{32'h01B2_0010, 32'h82A2_FFFF, 32'h8322_0000, 32'h0002_0005, 32'h0140_0000,
    32'h0100_0000, 32'hFF50_0000, 32'h8101_0000, 32'h8301_0000, 32'hFF01_0000, 32'h0501_0000, 32'h0103_0000};
  pch_power_cond_subcmd u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .pwr_cond_idx, .pwr_cond_forced, .timer_running);
  pch_host_model u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
  // register access through the host
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, rdat, rerr);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    u_host.xfer(1'b0, a, 32'h0, rdat, rerr);
  endtask : rd
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // reference model of one command, returns abort
  function automatic logic mdl(input logic [31:0] c);
    logic [7:0] k;
    logic [4:0] sel;
    logic       ab;
    int         t;
    k = c[23:16];
    for (int i = 0; i < NCOND; i++) sel[i] = c[31:24] == COND_ID[i] || (c[31:24] == COND_ALL && k[3:0] != SUB_GOTO);
    ab = !epc || sel == 5'h00 || k[3:0] > SUB_TIMER || (k[4] && k[3:0] != SUB_GOTO && (sel & ~savm) != 5'h00);
    forced = 1'b0;
    for (int i = 0; i < NCOND; i++) begin
      if (!ab && sel[i]) begin
        case (k[3:0])
          SUB_RESTORE: begin
            cur[i] = k[6] ? DEF_TMR[i] : sav[i];
            cen[i] = k[6] ? DEF_EN[i] : sen[i];
            if (k[4]) sav[i] = cur[i];
          end
          SUB_GOTO: begin
            forced = 1'b1;
            fidx = i;
          end
          default: begin
            t = k[7] ? c[15:0] * UNITS_PER_MINUTE : c[15:0];
            cur[i] = t > TMR_MAX ? TMR_MAX : t;
            cen[i] = k[5] && c[15:0] != 16'h0;
            if (k[4]) sav[i] = cur[i];
            if (k[4]) sen[i] = cen[i];
          end
        endcase
      end
    end
    return ab;
  endfunction : mdl
  // compare flags, ports and every timer with the model
  task automatic check_all(input logic ab);
    logic [4:0] rm;
    rd(ADDR_ERROR);
    `CHK("error", {29'h0, ab, 2'h0}, rdat)
    rd(ADDR_STATUS);
    `CHK("status", {24'h0, STATUS_RST | {7'h0, ab}}, rdat)
    for (int i = 0; i < NCOND; i++) rm[i] = cen[i][0] && !forced;
    `CHK("forced", forced, pwr_cond_forced)
    `CHK("cond", forced ? 3'(fidx) : COND_NONE, pwr_cond_idx)
    `CHK("running", rm, timer_running)
    rd(ADDR_PWR_STATE);
    `CHK("power state", {21'h0, rm, forced, forced, 1'b0, forced ? 3'(fidx) : COND_NONE}, rdat)
    for (int i = 0; i < NCOND; i++) begin
      wr(ADDR_TMR_SEL, 32'(i));
      rd(ADDR_TMR_CUR);
      `CHK("current", {cen[i][0], 9'h0, 22'(cur[i])}, rdat)
      rd(ADDR_TMR_SAVED);
      `CHK("saved", {sen[i][0], 9'h0, 22'(sav[i])}, rdat)
    end
  endtask : check_all
  task automatic run(input logic [31:0] c);
    logic ab;
    ab = mdl(c);
    u_host.cmd(c[31:24], c[23:16], c[15:0]);
    check_all(ab);
  endtask : run
  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    close_out();
  end
  // directed table, feature off, non-savable, then random commands
  initial begin
    for (int i = 0; i < NCOND; i++) begin
      cur[i] = DEF_TMR[i];
      sav[i] = DEF_TMR[i];
      cen[i] = DEF_EN[i];
      sen[i] = DEF_EN[i];
    end
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    check_all(1'b0);
    rd(8'hFC);
    `CHK("unmapped", 1'b1, rerr)
    foreach (plan[j]) run(plan[j]);
    wr(ADDR_EPC_CTRL, 32'h0);
    epc = 1'b0;
    run(32'h0140_0000);
    wr(ADDR_EPC_CTRL, 32'h1);
    epc = 1'b1;
    wr(ADDR_COND_CAPS, 32'h0000_1F1F);
    savm = 5'h00;
    run(32'h0112_0020);
    run(32'hFF50_0000);
    wr(ADDR_COND_CAPS, 32'h001F_1F1F);
    savm = 5'h1F;
    repeat (24) begin
      r = xs();
      run({r[2:0] > 3'd4 ? COND_ALL : COND_ID[r[2:0]], r[7:4], 4'(r[9:8] % 3), r[31:16]});
    end
    close_out();
  end
endmodule : pch_power_cond_subcmd_test
bind pch_power_cond_subcmd pch_properties u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .prdata, .pslverr, .pwr_cond_idx, .pwr_cond_forced, .timer_running);
